// >>> hdsl_link_ctrl.sv
// Purpose: link control of a serial port acting as slave on a half-duplex polled link
// Assumes: framing and character engines outside; they report poll, ack, nak and packet events as pulses
// Notes: delays count whole units; a delay of n units lasts at least n and at most n+1 units
// Operation
// - line rates 300 up to 38400 selectable
// - line modes: none, modem RTS/CTS, multidrop
// - EOT suppressed: no reply when nothing queued
// - duplicate packets detected and discarded
// - poll timer runs only while message pending
// - poll timeout in 20 ms units, error, drop
// - poll timeout zero disables the timer
// - RTS held off-delay after last character
// - wait send delay before sampling CTS
// - resend unacknowledged packet up to retry count
// - no handshaking: pre-transmit delay before sending
// - modem: pre-transmit delay before raising RTS
//
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/100ps
`include "hdsl_map.svh"
module hdsl_link_ctrl
  import hdsl_pkg::*;
#(
  parameter int MS_CYCLES = `HDSL_MS_NS / `HDSL_CLK_NS
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic cts_pin,
  output logic rts_pin,
  input wire logic message_request,
  input wire logic poll_rx,
  input wire logic rx_last_char,
  input wire logic ack_rx,
  input wire logic nak_rx,
  input wire logic pkt_rx_valid,
  input wire logic [7:0] pkt_tag,
  output logic pkt_accept,
  output logic pkt_drop,
  output logic tx_go,
  output logic tx_is_msg,
  input wire logic tx_last_char,
  output logic msg_error,
  output logic msg_done,
  output logic baud_tick,
  output logic irq
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [15:0] ctrl; // rate, line mode, eot suppress, duplicate detect
  logic [15:0] poll_to; // poll timeout, 20 ms units
  logic [15:0] rts_off; // rts off delay, 20 ms units
  logic [15:0] rts_send; // rts send delay, 20 ms units
  logic [7:0] retries; // resend limit
  logic [15:0] pre_tx; // pre-transmit delay, 1 ms units
  logic [3:0] status; // sticky events
  logic [3:0] mask; // interrupt enables
  logic [3:0] ev; // event pulses this cycle
  hdsl_state_e state; // sequencer state
  hdsl_line_e line; // decoded line setting
  logic msg_pend; // own message waiting for a poll
  logic [7:0] retry_cnt; // resends used so far
  assign line = hdsl_line_e'(ctrl[`HDSL_F_LINE]);
  // register writes; status clears by writing ones, a new event wins
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ctrl <= `HDSL_CTRL_RST;
      poll_to <= `HDSL_ZERO16;
      rts_off <= `HDSL_ZERO16;
      rts_send <= `HDSL_ZERO16;
      retries <= `HDSL_ZERO8;
      pre_tx <= `HDSL_ZERO16;
      mask <= 4'h0;
      status <= 4'h0;
    end
    else
    begin
      if (reg_wr)
      begin
        case (reg_addr)
          `HDSL_A_CTRL: ctrl <= reg_wdata;
          `HDSL_A_POLL_TO: poll_to <= reg_wdata;
          `HDSL_A_RTS_OFF: rts_off <= reg_wdata;
          `HDSL_A_RTS_SEND: rts_send <= reg_wdata;
          `HDSL_A_RETRIES: retries <= reg_wdata[7:0];
          `HDSL_A_PRE_TX: pre_tx <= reg_wdata;
          `HDSL_A_MASK: mask <= reg_wdata[3:0];
          default: ; // status handled below, others read only
        endcase
      end
      if (reg_wr && reg_addr == `HDSL_A_STATUS)
        status <= (status & ~reg_wdata[3:0]) | ev;
      else
        status <= status | ev;
    end
  end
  // read data stands the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      reg_rdata <= `HDSL_ZERO16;
    else if (reg_rd)
    begin
      case (reg_addr)
        `HDSL_A_CTRL: reg_rdata <= ctrl;
        `HDSL_A_POLL_TO: reg_rdata <= poll_to;
        `HDSL_A_RTS_OFF: reg_rdata <= rts_off;
        `HDSL_A_RTS_SEND: reg_rdata <= rts_send;
        `HDSL_A_RETRIES: reg_rdata <= {8'h00, retries};
        `HDSL_A_PRE_TX: reg_rdata <= pre_tx;
        `HDSL_A_STATUS: reg_rdata <= {12'h000, status};
        `HDSL_A_MASK: reg_rdata <= {12'h000, mask};
        `HDSL_A_STATE: reg_rdata <= {retry_cnt, 3'h0, msg_pend, 1'b0, 3'(state)};
        default: reg_rdata <= `HDSL_ZERO16;
      endcase
    end
    else
      reg_rdata <= `HDSL_ZERO16;
  end
  assign irq = |(status & mask);
  // ----------------------------------------------------------------
  // time bases and baud enable
  // ----------------------------------------------------------------
  logic [31:0] ms_div; // 1 ms prescaler
  logic [4:0] u20_div; // counts ms ticks into 20 ms
  logic ms_tick; // one cycle per ms
  logic u20_tick; // one cycle per 20 ms
  logic [19:0] baud_div; // bit rate divider
  logic [19:0] baud_max; // reload for selected rate
  assign ms_tick = (ms_div == 32'(MS_CYCLES - 1));
  assign u20_tick = ms_tick && (u20_div == 5'(`HDSL_UNIT_MS - 1));
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ms_div <= 32'h0;
      u20_div <= 5'h0;
    end
    else
    begin
      ms_div <= ms_tick ? 32'h0 : ms_div + 32'h1;
      if (u20_tick)
        u20_div <= 5'h0;
      else if (ms_tick)
        u20_div <= u20_div + 5'h1;
    end
  end
  // divisor per selected rate, 300 to 38400 bit/s
  always_comb
  begin
    case (ctrl[`HDSL_F_RATE])
      3'h0: baud_max = 20'(`HDSL_ONE_NS / `HDSL_CLK_NS / 300 - 1);
      3'h1: baud_max = 20'(`HDSL_ONE_NS / `HDSL_CLK_NS / 600 - 1);
      3'h2: baud_max = 20'(`HDSL_ONE_NS / `HDSL_CLK_NS / 1200 - 1);
      3'h3: baud_max = 20'(`HDSL_ONE_NS / `HDSL_CLK_NS / 2400 - 1);
      3'h4: baud_max = 20'(`HDSL_ONE_NS / `HDSL_CLK_NS / 4800 - 1);
      3'h5: baud_max = 20'(`HDSL_ONE_NS / `HDSL_CLK_NS / 9600 - 1);
      3'h6: baud_max = 20'(`HDSL_ONE_NS / `HDSL_CLK_NS / 19200 - 1);
      default: baud_max = 20'(`HDSL_ONE_NS / `HDSL_CLK_NS / 38400 - 1);
    endcase
  end
  // bit rate enable for the character engine
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      baud_div <= 20'h0;
      baud_tick <= 1'b0;
    end
    else
    begin
      baud_tick <= (baud_div >= baud_max);
      baud_div <= (baud_div >= baud_max) ? 20'h0 : baud_div + 20'h1;
    end
  end
  // ----------------------------------------------------------------
  // cts synchroniser
  // ----------------------------------------------------------------
  logic cts_meta; // first stage, read only by cts_s
  logic cts_s; // safe cts level
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cts_meta <= 1'b0;
      cts_s <= 1'b0;
    end
    else
    begin
      cts_meta <= cts_pin;
      cts_s <= cts_meta;
    end
  end
  // ----------------------------------------------------------------
  // duplicate packet filter
  // ----------------------------------------------------------------
  logic [7:0] last_tag; // tag of the last accepted packet
  logic have_tag; // last_tag is valid
  logic is_dup; // this packet repeats the last one
  assign is_dup = ctrl[`HDSL_F_DUP_EN] && have_tag && (pkt_tag == last_tag);
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      last_tag <= `HDSL_ZERO8;
      have_tag <= 1'b0;
      pkt_accept <= 1'b0;
      pkt_drop <= 1'b0;
    end
    else
    begin
      pkt_accept <= pkt_rx_valid && !is_dup;
      pkt_drop <= pkt_rx_valid && is_dup;
      if (pkt_rx_valid)
      begin
        last_tag <= pkt_tag;
        have_tag <= 1'b1;
      end
    end
  end
  // ----------------------------------------------------------------
  // transmit sequencer
  // ----------------------------------------------------------------
  logic [15:0] dly; // remaining delay units
  logic unit_tick; // tick of the unit the current delay uses
  logic [15:0] poll_cnt; // 20 ms units waited for a poll
  logic poll_expire; // poll timeout reached
  logic retry_left; // another resend allowed
  assign unit_tick = (state == ST_PRE) ? ms_tick : u20_tick;
  assign retry_left = (retry_cnt < retries);
  // poll timer: only while a message waits, zero setting disables it
  // fires on the tick after the count is full, so the wait is never shorter than the setting
  assign poll_expire = msg_pend && (state == ST_IDLE) && u20_tick && (poll_to != `HDSL_ZERO16)
    && (poll_cnt >= poll_to);
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      poll_cnt <= `HDSL_ZERO16;
    else if (!msg_pend || poll_rx || poll_expire)
      poll_cnt <= `HDSL_ZERO16;
    else if (u20_tick && state == ST_IDLE)
      poll_cnt <= poll_cnt + 16'h1;
  end
  // main sequence: poll, delay, rts/cts, send, off delay, ack
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
      dly <= `HDSL_ZERO16;
      rts_pin <= 1'b0;
      tx_is_msg <= 1'b0;
      msg_pend <= 1'b0;
      retry_cnt <= `HDSL_ZERO8;
      msg_error <= 1'b0;
      msg_done <= 1'b0;
      ev <= 4'h0;
    end
    else
    begin
      msg_error <= 1'b0;
      msg_done <= 1'b0;
      ev <= {pkt_rx_valid && is_dup, 3'h0};
      if (message_request)
        msg_pend <= 1'b1;
      case (state)
        ST_IDLE:
        begin
          if (poll_expire)
          begin
            msg_pend <= 1'b0;
            msg_error <= 1'b1;
            ev[`HDSL_S_ERR] <= 1'b1;
          end
          else if (poll_rx && (msg_pend || !ctrl[`HDSL_F_EOT_SUP]))
          begin
            tx_is_msg <= msg_pend;
            dly <= pre_tx;
            state <= ST_PRE;
          end
        end
        // pre-transmit gap, counted from the end of the poll
        ST_PRE:
        begin
          if (rx_last_char)
            dly <= pre_tx;
          else if (ms_tick && dly == `HDSL_ZERO16)
          begin
            if (line == LINE_MODEM)
            begin
              rts_pin <= 1'b1;
              dly <= rts_send;
              state <= ST_RTS_WAIT;
            end
            else
              state <= ST_TX;
          end
          else if (ms_tick)
            dly <= dly - 16'h1;
        end
        // modem warm-up, then one look at cts
        ST_RTS_WAIT:
        begin
          if (u20_tick && dly == `HDSL_ZERO16)
          begin
            if (cts_s)
              state <= ST_TX;
            else
            begin
              rts_pin <= 1'b0;
              ev[`HDSL_S_CTS] <= 1'b1;
              state <= ST_IDLE;
            end
          end
          else if (u20_tick)
            dly <= dly - 16'h1;
        end
        ST_TX:
        begin
          if (tx_last_char)
          begin
            dly <= rts_off;
            if (line == LINE_MODEM)
              state <= ST_OFF;
            else
              state <= tx_is_msg ? ST_ACK_WAIT : ST_IDLE;
          end
        end
        // keep rts up while the modem drains its last character
        ST_OFF:
        begin
          if (u20_tick && dly == `HDSL_ZERO16)
          begin
            rts_pin <= 1'b0;
            state <= tx_is_msg ? ST_ACK_WAIT : ST_IDLE;
          end
          else if (u20_tick)
            dly <= dly - 16'h1;
        end
        ST_ACK_WAIT:
        begin
          if (ack_rx)
          begin
            msg_pend <= 1'b0;
            retry_cnt <= `HDSL_ZERO8;
            msg_done <= 1'b1;
            ev[`HDSL_S_SENT] <= 1'b1;
            state <= ST_IDLE;
          end
          else if (nak_rx && retry_left)
          begin
            retry_cnt <= retry_cnt + 8'h1;
            dly <= pre_tx;
            state <= ST_PRE;
          end
          else if (nak_rx)
          begin
            msg_pend <= 1'b0;
            retry_cnt <= `HDSL_ZERO8;
            msg_error <= 1'b1;
            ev[`HDSL_S_ERR] <= 1'b1;
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
  assign tx_go = (state == ST_TX);
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  rts_only_modem_a: assert property (rts_pin |-> line == LINE_MODEM) else $error("rts outside modem mode");
  eot_quiet_a: assert property (state == ST_IDLE && poll_rx && !msg_pend && ctrl[`HDSL_F_EOT_SUP] && !poll_expire
    |=> state == ST_IDLE) else $error("reply sent while suppressed");
  dup_drop_a: assert property (pkt_rx_valid && is_dup |=> pkt_drop && !pkt_accept) else $error("duplicate kept");
  poll_idle_a: assert property (!msg_pend |=> poll_cnt == `HDSL_ZERO16) else $error("poll timer ran idle");
  poll_drop_a: assert property (poll_expire && state == ST_IDLE |=> !msg_pend && msg_error)
    else $error("timeout not reported");
  poll_off_a: assert property (poll_to == `HDSL_ZERO16 |-> !poll_expire) else $error("zero timeout fired");
  rts_hold_a: assert property (state == ST_OFF && dly != `HDSL_ZERO16 |=> rts_pin) else $error("rts dropped early");
  cts_look_a: assert property (state == ST_RTS_WAIT && u20_tick && dly == `HDSL_ZERO16 && !cts_s
    |=> !tx_go && !rts_pin) else $error("sent without cts");
  tx_after_pre_a: assert property ($rose(tx_go) && line != LINE_MODEM |-> $past(state) == ST_PRE && $past(ms_tick))
    else $error("send skipped pre delay");
  retry_cap_a: assert property (retry_cnt <= retries || $changed(retries)) else $error("retry count overran");
  retry_end_a: assert property (state == ST_ACK_WAIT && nak_rx && !ack_rx && !retry_left
    |=> retry_cnt == `HDSL_ZERO8 && msg_error) else $error("exhausted message kept");
  modem_send_c: cover property (state == ST_RTS_WAIT ##1 tx_go);
  retry_c: cover property (nak_rx && retry_left && state == ST_ACK_WAIT);
  timeout_c: cover property (poll_expire);
  dup_c: cover property (pkt_drop);
endmodule : hdsl_link_ctrl

// >>> hdsl_map.svh
// Purpose: register offsets, field positions, reset values and timing figures of the slave link control block
// Assumes: 100 MHz system clock, word index addressing on the register port
// Notes: definitions only
`ifndef HDSL_MAP_SVH
`define HDSL_MAP_SVH
// ----------------------------------------------------------------
// register indices
// ----------------------------------------------------------------
`define HDSL_A_CTRL 4'h0
`define HDSL_A_POLL_TO 4'h1
`define HDSL_A_RTS_OFF 4'h2
`define HDSL_A_RTS_SEND 4'h3
`define HDSL_A_RETRIES 4'h4
`define HDSL_A_PRE_TX 4'h5
`define HDSL_A_STATUS 4'h6
`define HDSL_A_MASK 4'h7
`define HDSL_A_STATE 4'h8
// ----------------------------------------------------------------
// control fields and reset values
// ----------------------------------------------------------------
`define HDSL_F_RATE 2:0
`define HDSL_F_LINE 4:3
`define HDSL_F_EOT_SUP 5
`define HDSL_F_DUP_EN 6
`define HDSL_CTRL_RST 16'h0040
`define HDSL_ZERO16 16'h0000
`define HDSL_ZERO8 8'h00
// ----------------------------------------------------------------
// status bits
// ----------------------------------------------------------------
`define HDSL_S_ERR 0
`define HDSL_S_SENT 1
`define HDSL_S_CTS 2
`define HDSL_S_DUP 3
// ----------------------------------------------------------------
// timing: clock period, millisecond and second in ns; the long unit in ms
// ----------------------------------------------------------------
`define HDSL_CLK_NS 10
`define HDSL_MS_NS 1000000
`define HDSL_UNIT_MS 20
`define HDSL_ONE_NS 1000000000
`endif

// >>> hdsl_master_model.sv
// Purpose: polling master and half-duplex modem seen from the slave link control block
// Assumes: one clock; the bench asks for each poll through poll_req
// Notes: each frame lasts eight cycles; the reply waits until request-to-send has dropped
`timescale 1ns/100ps
module hdsl_master_model
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic poll_req,
  input wire logic cts_grant,
  input wire logic nak_mode,
  input wire logic rts_pin,
  input wire logic tx_go,
  input wire logic tx_is_msg,
  output logic poll_rx,
  output logic cts_pin,
  output logic tx_last_char,
  output logic ack_rx,
  output logic nak_rx,
  output logic [7:0] tx_cnt
);
  logic [3:0] cts_dly; // rts seen through the modem's own lag
  logic [3:0] tx_len; // cycles spent in the current frame
  logic [3:0] ack_dly; // gap before the reply
  logic ack_due; // a message went out and is owed a reply
  logic go_q; // tx_go one cycle back, for frame counting
  // ----------------------------------------------------------------
  // modem lines and polls
  // ----------------------------------------------------------------
  // cts lags rts, so a slave that checks too early sees it low
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cts_dly <= 4'h0;
      cts_pin <= 1'b0;
      poll_rx <= 1'b0;
    end
    else
    begin
      cts_dly <= {cts_dly[2:0], rts_pin};
      cts_pin <= cts_grant & cts_dly[3];
      poll_rx <= poll_req;
    end
  end
  // ----------------------------------------------------------------
  // frames and replies
  // ----------------------------------------------------------------
  // the master only answers once the slave's carrier is gone
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      go_q <= 1'b0;
      tx_len <= 4'h0;
      tx_last_char <= 1'b0;
      tx_cnt <= 8'h00;
      ack_due <= 1'b0;
      ack_dly <= 4'h0;
      ack_rx <= 1'b0;
      nak_rx <= 1'b0;
    end
    else
    begin
      go_q <= tx_go;
      tx_last_char <= 1'b0;
      ack_rx <= 1'b0;
      nak_rx <= 1'b0;
      if (tx_go && !go_q)
        tx_cnt <= tx_cnt + 8'h01;
      if (!tx_go)
        tx_len <= 4'h0;
      else if (tx_len == 4'h7)
      begin
        tx_len <= 4'h0;
        tx_last_char <= 1'b1;
      end
      else
        tx_len <= tx_len + 4'h1;
      if (tx_last_char && tx_is_msg)
        ack_due <= 1'b1;
      else if (ack_due && !rts_pin)
      begin
        ack_dly <= ack_dly + 4'h1;
        if (ack_dly == 4'h8)
        begin
          ack_due <= 1'b0;
          ack_dly <= 4'h0;
          ack_rx <= !nak_mode;
          nak_rx <= nak_mode;
        end
      end
    end
  end
endmodule : hdsl_master_model

// >>> hdsl_pkg.sv
// Purpose: shared types of the slave link control block
// Assumes: nothing beyond the map header
// Notes: states carry no explicit codes
package hdsl_pkg;
  // sequencer states
  typedef enum logic [2:0] {ST_IDLE, ST_PRE, ST_RTS_WAIT, ST_TX, ST_OFF, ST_ACK_WAIT} hdsl_state_e;
  // line control settings
  typedef enum logic [1:0] {LINE_NONE, LINE_MODEM, LINE_MULTIDROP} hdsl_line_e;
endpackage : hdsl_pkg

// >>> tb_hdsl_link_ctrl.sv
// Purpose: self-checking bench of the slave link control block
// Assumes: one millisecond shortened to MS_T cycles; bit rates keep real 100 MHz timing
// Notes: register reads and packet verdicts are checked through queues by a monitor
`timescale 1ns/100ps
`include "hdsl_map.svh"
module tb_hdsl_link_ctrl
  import hdsl_pkg::*;
;
  localparam int MS_T = 10; // cycles in a shortened millisecond
  localparam int UNIT = 20 * MS_T; // one 20 ms step
  int rate_bps[8] = '{300, 600, 1200, 2400, 4800, 9600, 19200, 38400}; // rate field codes
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic message_request = 1'b0;
  logic rx_last_char = 1'b0;
  logic pkt_rx_valid = 1'b0;
  logic [7:0] pkt_tag = 8'h00;
  logic poll_req = 1'b0; // asks the master model for a poll
  logic cts_grant = 1'b1; // modem grants clearance
  logic nak_mode = 1'b0; // master refuses every message
  logic [15:0] reg_rdata;
  logic cts_pin, rts_pin, poll_rx, ack_rx, nak_rx, tx_last_char, tx_go, tx_is_msg;
  logic pkt_accept, pkt_drop, msg_error, msg_done, baud_tick, irq, pe, rd_d;
  logic [7:0] tx_cnt;
  logic [7:0] tag;
  logic [15:0] d;
  logic [15:0] rd_q[$]; // expected read data, oldest first
  logic pkt_q[$]; // expected drop verdicts
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int seed = 74513;
  int n, k, t0;
  always #5 clk_sys = ~clk_sys;
  hdsl_link_ctrl #(.MS_CYCLES(MS_T)) i_dut (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .cts_pin, .rts_pin, .message_request, .poll_rx, .rx_last_char, .ack_rx, .nak_rx,
    .pkt_rx_valid, .pkt_tag, .pkt_accept, .pkt_drop, .tx_go, .tx_is_msg, .tx_last_char, .msg_error,
    .msg_done, .baud_tick, .irq);
  hdsl_master_model i_master (.clk_sys, .rst, .poll_req, .cts_grant, .nak_mode, .rts_pin, .tx_go,
    .tx_is_msg, .poll_rx, .cts_pin, .tx_last_char, .ack_rx, .nak_rx, .tx_cnt);
  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic rng(input string nm, input int v, input int lo, input int hi);
    check(nm, (v >= lo && v <= hi) ? 16'h0001 : 16'h0000, 16'h0001);
  endtask : rng
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  // ----------------------------------------------------------------
  // drivers
  // ----------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    rd_q.push_back(exp);
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask : rd
  task automatic pkt(input logic [7:0] t, input logic drop);
    @(posedge clk_sys);
    pkt_tag <= t;
    pkt_rx_valid <= 1'b1;
    pkt_q.push_back(drop);
    @(posedge clk_sys);
    pkt_rx_valid <= 1'b0;
  endtask : pkt
  // 0 queues a message, 1 asks for a poll, else ends a received packet
  task automatic pulse(input int s);
    @(posedge clk_sys);
    case (s)
      0: message_request <= 1'b1;
      1: poll_req <= 1'b1;
      default: rx_last_char <= 1'b1;
    endcase
    @(posedge clk_sys);
    message_request <= 1'b0;
    poll_req <= 1'b0;
    rx_last_char <= 1'b0;
  endtask : pulse
  function automatic logic sel(input int s);
    case (s)
      0: sel = tx_go;
      1: sel = msg_error;
      2: sel = msg_done;
      3: sel = rts_pin;
      4: sel = !rts_pin;
      default: sel = baud_tick;
    endcase
  endfunction : sel
  // bounded wait; cnt reaches lim when the event never showed
  task automatic wait_ev(input int s, input int lim, output int cnt);
    cnt = 0;
    do
    begin
      @(posedge clk_sys);
      cnt++;
    end
    while (sel(s) !== 1'b1 && cnt < lim);
  endtask : wait_ev
  // ----------------------------------------------------------------
  // monitor: read data one cycle after the strobe, packet verdicts
  // ----------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      bad_count++;
      $display("timeout");
      finish_test();
    end
    if (rd_d === 1'b1)
      check("reg_rdata", reg_rdata, rd_q.pop_front());
    rd_d = reg_rd;
    if ((pkt_accept | pkt_drop) === 1'b1)
    begin
      pe = pkt_q.pop_front();
      check("pkt_drop", {15'h0000, pkt_drop}, {15'h0000, pe});
      check("pkt_accept", {15'h0000, pkt_accept}, {15'h0000, !pe});
    end
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    rd(`HDSL_A_CTRL, `HDSL_CTRL_RST);
    for (k = 1; k < 10; k++)
      rd(4'(k), 16'h0000);
    d = 16'($random(seed));
    wr(`HDSL_A_POLL_TO, d);
    wr(`HDSL_A_STATE, 16'hFFFF);
    wr(4'hF, 16'hFFFF);
    rd(`HDSL_A_POLL_TO, d);
    rd(`HDSL_A_STATE, 16'h0000);
    $display("test registers done");
    for (k = 5; k < 8; k++)
    begin
      wr(`HDSL_A_CTRL, 16'h0040 | 16'(k));
      wait_ev(5, 30000, n);
      wait_ev(5, 30000, n);
      rng("baud period", n, 100000000 / rate_bps[k] - 2, 100000000 / rate_bps[k] + 2);
    end
    $display("test rates done");
    // line none then multidrop: plain pre-transmit gap, no rts
    wr(`HDSL_A_POLL_TO, 16'h0000);
    wr(`HDSL_A_PRE_TX, 16'h0002);
    for (k = 0; k < 2; k++)
    begin
      wr(`HDSL_A_CTRL, 16'h0040 | 16'(k << 4));
      pulse(1);
      wait_ev(0, 100, n);
      rng("pre-transmit gap", n, 2 * MS_T, 3 * MS_T + 4);
      check("tx_is_msg", tx_is_msg, 16'h0000);
      check("rts_pin", rts_pin, 16'h0000);
      repeat (20) @(posedge clk_sys);
    end
    wr(`HDSL_A_CTRL, 16'h0060);
    pulse(1);
    wait_ev(0, 100, n);
    check("suppressed reply", 16'(n), 16'h0064);
    $display("test reply done");
    // a zero timeout waits for ever, then the message goes out
    wr(`HDSL_A_CTRL, 16'h0040);
    wr(`HDSL_A_PRE_TX, 16'h0000);
    wr(`HDSL_A_MASK, 16'h0002);
    pulse(0);
    wait_ev(1, 4 * UNIT, n);
    check("no poll timeout", 16'(n), 16'(4 * UNIT));
    rd(`HDSL_A_STATE, 16'h0010);
    pulse(1);
    wait_ev(0, 100, n);
    check("tx_is_msg", tx_is_msg, 16'h0001);
    wait_ev(2, 100, n);
    rng("msg_done", n, 1, 99);
    @(posedge clk_sys);
    check("irq", irq, 16'h0001);
    rd(`HDSL_A_STATUS, 16'h0002);
    wr(`HDSL_A_STATUS, 16'h000F);
    @(posedge clk_sys);
    check("irq", irq, 16'h0000);
    $display("test message done");
    // the timer must not run while nothing is pending
    wr(`HDSL_A_MASK, 16'h0000);
    wr(`HDSL_A_POLL_TO, 16'h0002);
    repeat (3 * UNIT) @(posedge clk_sys);
    pulse(0);
    wait_ev(1, 4 * UNIT, n);
    rng("poll timeout", n, 2 * UNIT - 2, 3 * UNIT + 4);
    rd(`HDSL_A_STATE, 16'h0000);
    check("irq masked", irq, 16'h0000);
    wr(`HDSL_A_MASK, 16'h0001);
    @(posedge clk_sys);
    check("irq", irq, 16'h0001);
    wr(`HDSL_A_STATUS, 16'h0001);
    @(posedge clk_sys);
    check("irq", irq, 16'h0000);
    wr(`HDSL_A_POLL_TO, 16'h0000);
    $display("test timeout done");
    // every send refused: retry count bounds the resends
    nak_mode <= 1'b1;
    for (k = 0; k < 3; k += 2)
    begin
      wr(`HDSL_A_RETRIES, 16'(k));
      t0 = tx_cnt;
      pulse(0);
      pulse(1);
      wait_ev(1, 2000, n);
      check("sends", 16'(tx_cnt - t0), 16'(k + 1));
      rd(`HDSL_A_STATE, 16'h0000);
      rd(`HDSL_A_STATUS, 16'h0001);
      wr(`HDSL_A_STATUS, 16'h000F);
    end
    nak_mode <= 1'b0;
    $display("test retries done");
    // modem line: gap, send delay, off delay, then a refusal
    wr(`HDSL_A_CTRL, 16'h0048);
    wr(`HDSL_A_RTS_SEND, 16'h0001);
    wr(`HDSL_A_RTS_OFF, 16'h0001);
    wr(`HDSL_A_PRE_TX, 16'h0003);
    pulse(1);
    pulse(2);
    wait_ev(3, 200, n);
    rng("rts after packet", n, 3 * MS_T, 4 * MS_T + 4);
    wait_ev(0, 3 * UNIT, n);
    rng("send delay", n, UNIT, 2 * UNIT + 8);
    check("rts_pin", rts_pin, 16'h0001);
    wait_ev(4, 3 * UNIT, n);
    rng("off delay", n, UNIT, 2 * UNIT + 12);
    cts_grant <= 1'b0;
    t0 = tx_cnt;
    pulse(1);
    wait_ev(3, 200, n);
    wait_ev(4, 3 * UNIT, n);
    rng("refused rts", n, UNIT, 2 * UNIT + 8);
    check("no send", 16'(tx_cnt - t0), 16'h0000);
    rd(`HDSL_A_STATUS, 16'h0004);
    cts_grant <= 1'b1;
    $display("test modem done");
    tag = {1'b1, 7'($random(seed))};
    pkt(tag, 1'b0);
    pkt(tag, 1'b1);
    pkt(tag + 8'h01, 1'b0);
    wr(`HDSL_A_CTRL, 16'h0000);
    pkt(tag + 8'h01, 1'b0);
    rd(`HDSL_A_STATUS, 16'h000C);
    repeat (10) @(posedge clk_sys);
    $display("test duplicates done");
    finish_test();
  end
endmodule : tb_hdsl_link_ctrl
